//--- rtl/dram_ctl_defines.vh
// Functional notes
// - pattern mode select 00 returns alternating bits
// - eight-beat pattern read outputs positions 0..7
// - chopped read: addr bit2 picks nibble
// - position 0 is lsb, 7 is msb
// - enable takes effect after mrd and mod waits; the code waits the mod time only and never uses mrd
// - pattern burst follows after additive plus cas latency
// - mode set: bank picks register, address is value
// - device accepts long and short calibration commands
// - calibration accepted during dll reset and lock
// - calibration pin current path off when done
// - enable zero ignores select, normal array access
`ifndef DRAM_CTL_DEFINES_VH
`define DRAM_CTL_DEFINES_VH
// ----------------------------------------
// command encodings {cs_n, ras_n, cas_n, we_n}
// ----------------------------------------
`define CMD_MRS      4'h0
`define CMD_READ     4'h5
`define CMD_WRITE    4'h4
`define CMD_ZQ       4'h6
// ----------------------------------------
// mode register fields
// ----------------------------------------
`define MR3_PAT_EN   2
`define MR0_BL_LO    0
`define MR0_CL_LO    4
`define MR1_AL_LO    3
`define A_BC_BIT     12
`define A_ZQ_LONG    10
`define SEL_PATTERN  2'h0
`define PATTERN_BYTE 8'haa
// ----------------------------------------
// timing in clocks
// ----------------------------------------
`define T_MRD_CK     4
`define T_MOD_CK     12
`define T_ZQINIT_CK  512
`define T_ZQOPER_CK  256
`define T_ZQCS_CK    64
`endif

//--- rtl/burst_shifter.v
`timescale 1ns/1ps
`include "dram_ctl_defines.vh"
// ----------------------------------------
// burst shifter: serialises one beat per clock
// ----------------------------------------
module burst_shifter (
    // clock and reset
    input  wire       i_ref_clk,
    input  wire       i_rst_n,
    // load side
    input  wire       i_load,
    input  wire [7:0] i_bits,
    input  wire [3:0] i_beats,
    // beat side
    output reg        o_valid,
    output reg        o_bit
);
    reg [7:0] sh_q;   // remaining bits, lsb first
    reg [3:0] cnt_q;  // beats left

    // shift lsb out first so position 0 leaves first
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sh_q    <= 8'h00;
            cnt_q   <= 4'h0;
            o_valid <= 1'b0;
            o_bit   <= 1'b0;
        end else if (i_load) begin
            sh_q    <= {1'b0, i_bits[7:1]};
            cnt_q   <= i_beats - 4'h1;
            o_valid <= 1'b1;
            o_bit   <= i_bits[0];
        end else if (cnt_q != 4'h0) begin
            sh_q    <= {1'b0, sh_q[7:1]};
            cnt_q   <= cnt_q - 4'h1;
            o_valid <= 1'b1;
            o_bit   <= sh_q[0];
        end else begin
            o_valid <= 1'b0;
            o_bit   <= 1'b0;
        end
    end
endmodule // burst_shifter

//--- rtl/dram_mpr_mrs_zq_control.v
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`include "dram_ctl_defines.vh"
// ----------------------------------------
// mode set, pattern readout and calibration control
// ----------------------------------------
module dram_mpr_mrs_zq_control (
    // clock and reset
    input  wire        i_ref_clk,
    input  wire        i_rst_n,
    // command bus from the controller, same clock
    input  wire        i_cs_n,
    input  wire        i_ras_n,
    input  wire        i_cas_n,
    input  wire        i_we_n,
    input  wire [2:0]  i_ba,
    input  wire [13:0] i_addr,
    // array read data for normal reads
    input  wire [7:0]  i_array_bits,
    // read data out, one beat per clock
    output reg         o_dq_valid,
    output reg         o_dq_bit,
    // array access steering
    output reg         o_array_rd,
    output reg         o_array_wr,
    // mode register views
    output reg  [13:0] o_mode0,
    output reg  [13:0] o_mode1,
    output reg  [13:0] o_mode2,
    output reg  [13:0] o_mode3,
    // status
    output reg         o_pattern_mode,
    output reg         o_mode_busy,
    output reg         o_zq_busy,
    output reg         o_zq_long,
    output reg         o_zq_pin_on
);
    // ----------------------------------------
    // command decode
    // ----------------------------------------
    wire [3:0] cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};
    wire is_mrs   = (cmd == `CMD_MRS);
    wire is_read  = (cmd == `CMD_READ);
    wire is_write = (cmd == `CMD_WRITE);
    wire is_zq    = (cmd == `CMD_ZQ);

    reg  [13:0] mr_q [0:3];     // mode registers 0..3
    reg  [4:0]  mod_cnt_q;      // wait until new settings apply
    reg  [13:0] mr3_pend_q;     // mode register three value waiting for tmod
    reg         pend_q;         // mode register three update pending
    reg  [9:0]  zq_cnt_q;       // calibration time left
    reg  [5:0]  lat_cnt_q;      // read latency countdown
    reg  [7:0]  lat_bits_q;     // burst held until latency ends
    reg  [3:0]  lat_beats_q;    // beats held until latency ends
    reg         load_q;         // launch burst
    wire        sh_valid;
    wire        sh_bit;

    // ----------------------------------------
    // constants sized to the registers they load
    // ----------------------------------------
    // declared at the target width so no load silently drops bits
    localparam [4:0] t_mod_ck      = `T_MOD_CK;      // mode update wait
    localparam [9:0] t_zq_long_ck  = `T_ZQINIT_CK;   // long calibration span
    localparam [9:0] t_zq_short_ck = `T_ZQCS_CK;     // short calibration span
    localparam [7:0] pat_byte      = `PATTERN_BYTE;  // alternating pattern, lsb first

    // pattern mode active; reserved select codes return array data but array access stays off
    wire pat_on = mr_q[3][`MR3_PAT_EN];
    wire pat_sel_ok = (mr_q[3][1:0] == `SEL_PATTERN);

    // read latency = additive + cas latency
    function [5:0] read_latency;
        input [13:0] m0;
        input [13:0] m1;
        reg   [5:0]  cl;
        reg   [5:0]  al;
        begin
            cl = {2'b00, m0[`MR0_CL_LO+3:`MR0_CL_LO]} + 6'h4;
            case (m1[`MR1_AL_LO+1:`MR1_AL_LO])
                2'h1:    al = cl - 6'h1;
                2'h2:    al = cl - 6'h2;
                default: al = 6'h0;
            endcase
            read_latency = cl + al;
        end
    endfunction

    // chop decision: fixed chop, or on-the-fly with a12 low
    function chop_sel;
        input [1:0] bl;
        input       a12;
        begin
            case (bl)
                2'h2:    chop_sel = 1'b1;
                2'h1:    chop_sel = ~a12;
                default: chop_sel = 1'b0;
            endcase
        end
    endfunction

    wire       chop = chop_sel(mr_q[0][`MR0_BL_LO+1:`MR0_BL_LO], i_addr[`A_BC_BIT]);
    // nibble select: a2 picks lower or upper half of the pattern
    // both nibbles of the pattern carry 0,1,0,1 so either half starts low
    wire [7:0] pat_bits = (chop & i_addr[2]) ? {4'h0, pat_byte[7:4]}
                                             : pat_byte;
    wire [7:0] rd_bits  = (pat_on && pat_sel_ok) ? pat_bits
                                                 : i_array_bits;
    wire [3:0] rd_beats = chop ? 4'h4 : 4'h8;

    // ----------------------------------------
    // mode register set
    // ----------------------------------------
    // mode registers 0..2 load at once; register three waits tmod so
    // reads keep their old source until the new mode is in force
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            mr_q[0]    <= 14'h0000;
            mr_q[1]    <= 14'h0000;
            mr_q[2]    <= 14'h0000;
            mr_q[3]    <= 14'h0000;
            mr3_pend_q <= 14'h0000;
            pend_q     <= 1'b0;
            mod_cnt_q  <= 5'h00;
        end else begin
            if (is_mrs && (i_ba[2] == 1'b0)) begin
                // any accepted mode set restarts the update wait
                mod_cnt_q <= t_mod_ck;
                if (i_ba[1:0] == 2'h3) begin
                    mr3_pend_q <= i_addr;
                    pend_q     <= 1'b1;
                end else begin
                    mr_q[i_ba[1:0]] <= i_addr;
                end
            end else if (mod_cnt_q != 5'h00) begin
                mod_cnt_q <= mod_cnt_q - 5'h01;
                if ((mod_cnt_q == 5'h01) && pend_q) begin
                    mr_q[3] <= mr3_pend_q;
                    pend_q  <= 1'b0;
                end
            end
        end
    end

    // ----------------------------------------
    // read launch with latency
    // ----------------------------------------
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            lat_cnt_q   <= 6'h00;
            lat_bits_q  <= 8'h00;
            lat_beats_q <= 4'h0;
            load_q      <= 1'b0;
        end else begin
            load_q <= 1'b0;
            if (is_read) begin
                lat_cnt_q   <= read_latency(mr_q[0], mr_q[1]) - 6'h1;
                lat_bits_q  <= rd_bits;
                lat_beats_q <= rd_beats;
                if (read_latency(mr_q[0], mr_q[1]) == 6'h1) begin
                    load_q <= 1'b1;
                end
            end else if (lat_cnt_q != 6'h00) begin
                lat_cnt_q <= lat_cnt_q - 6'h01;
                if (lat_cnt_q == 6'h01) begin
                    load_q <= 1'b1;
                end
            end
        end
    end

    burst_shifter u_shift (
        .i_ref_clk (i_ref_clk),
        .i_rst_n   (i_rst_n),
        .i_load    (load_q),
        .i_bits    (lat_bits_q),
        .i_beats   (lat_beats_q),
        .o_valid   (sh_valid),
        .o_bit     (sh_bit)
    );

    // ----------------------------------------
    // impedance calibration
    // ----------------------------------------
    // accepted regardless of dll state; a new command restarts the count
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            zq_cnt_q  <= 10'h000;
            o_zq_long <= 1'b0;
        end else if (is_zq) begin
            o_zq_long <= i_addr[`A_ZQ_LONG];
            // address bit ten picks the long or the short span
            zq_cnt_q  <= i_addr[`A_ZQ_LONG] ? t_zq_long_ck : t_zq_short_ck;
        end else if (zq_cnt_q != 10'h000) begin
            zq_cnt_q <= zq_cnt_q - 10'h001;
        end
    end

    // ----------------------------------------
    // registered outputs
    // ----------------------------------------
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_dq_valid     <= 1'b0;
            o_dq_bit       <= 1'b0;
            o_array_rd     <= 1'b0;
            o_array_wr     <= 1'b0;
            o_mode0        <= 14'h0000;
            o_mode1        <= 14'h0000;
            o_mode2        <= 14'h0000;
            o_mode3        <= 14'h0000;
            o_pattern_mode <= 1'b0;
            o_mode_busy    <= 1'b0;
            o_zq_busy      <= 1'b0;
            o_zq_pin_on    <= 1'b0;
        end else begin
            o_dq_valid     <= sh_valid;
            o_dq_bit       <= sh_bit;
            // array touched only outside pattern mode
            o_array_rd     <= is_read & ~pat_on;
            o_array_wr     <= is_write & ~pat_on;
            o_mode0        <= mr_q[0];
            o_mode1        <= mr_q[1];
            o_mode2        <= mr_q[2];
            o_mode3        <= mr_q[3];
            o_pattern_mode <= pat_on;
            o_mode_busy    <= is_mrs | (mod_cnt_q > 5'h01);
            o_zq_busy      <= is_zq | (zq_cnt_q > 10'h001);
            // current path through the pin only while calibrating
            o_zq_pin_on    <= is_zq | (zq_cnt_q > 10'h001);
        end
    end
endmodule // dram_mpr_mrs_zq_control

//--- testbench/dram_ctl_assertions.sv
`timescale 1ns/1ps
`include "dram_ctl_defines.vh"
// ----------------------------------------
// port checker for the mode, pattern and calibration block
// ----------------------------------------
module dram_ctl_assertions (
    input wire        i_ref_clk,
    input wire        i_rst_n,
    input wire        i_cs_n,
    input wire        i_ras_n,
    input wire        i_cas_n,
    input wire        i_we_n,
    input wire [2:0]  i_ba,
    input wire [13:0] i_addr,
    input wire        o_dq_valid,
    input wire        o_dq_bit,
    input wire        o_array_rd,
    input wire        o_array_wr,
    input wire [13:0] o_mode0,
    input wire [13:0] o_mode1,
    input wire [13:0] o_mode3,
    input wire        o_pattern_mode,
    input wire        o_mode_busy,
    input wire        o_zq_busy,
    input wire        o_zq_long,
    input wire        o_zq_pin_on
);
    wire [3:0] cmd = {i_cs_n, i_ras_n, i_cas_n, i_we_n};     // decoded command code
    wire       mrs = cmd == `CMD_MRS;
    wire       rd  = cmd == `CMD_READ;
    wire       wr  = cmd == `CMD_WRITE;
    wire       zq  = cmd == `CMD_ZQ;
    wire       rl5 = o_mode0[7:4] == 4'h1 && o_mode1[4:3] == 2'h0; // five clock read latency
    reg        long_q;                                      // kind of the last calibration
    reg [9:0]  busy_q;                                      // cycles of calibration busy
    // measure the busy span of each calibration
    always @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            long_q <= 1'b0;
            busy_q <= 10'h000;
        end else if (zq) begin
            long_q <= i_addr[`A_ZQ_LONG];
            busy_q <= 10'h000;
        end else if (o_zq_busy) begin
            busy_q <= busy_q + 10'h001;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    sequence pat_start_s; o_dq_valid && !o_dq_bit ##1 o_dq_valid && o_dq_bit; endsequence
    sequence chop_s; o_dq_valid [*4] ##1 !o_dq_valid; endsequence
    sequence mrs_quiet_s; mrs && !i_ba[2] ##1 !mrs [*8] ##1 !mrs [*4]; endsequence
    mode_busy_a: assert property (mrs && !i_ba[2] |=> o_mode_busy)
        else $error("mode busy not raised");
    mode_busy_end_a: assert property (mrs_quiet_s |-> o_mode_busy ##1 !o_mode_busy)
        else $error("mode busy span wrong");
    mode_zero_load_a: assert property (mrs && i_ba == 3'h0 |-> ##2 o_mode0 == $past(i_addr, 2))
        else $error("mode0 not loaded");
    high_bank_ignored_a: assert property (mrs && i_ba[2] |-> ##2 $stable(o_mode0) && $stable(o_mode1))
        else $error("mode set with top bank bit took effect");
    mode_three_late_a: assert property (mrs && i_ba == 3'h3 |-> ##14 o_mode3 == $past(i_addr, 14))
        else $error("mode3 not applied after the wait");
    pattern_start_a: assert property (rd && rl5 && o_pattern_mode && o_mode3[1:0] == 2'h0 |-> ##7 pat_start_s)
        else $error("pattern burst late or wrong start");
    pattern_alt_a: assert property (o_dq_valid && $past(o_dq_valid) && o_pattern_mode |-> o_dq_bit != $past(o_dq_bit))
        else $error("pattern does not alternate");
    chop_len_a: assert property (rd && rl5 && o_mode0[1:0] == 2'h1 && !i_addr[`A_BC_BIT] |-> ##7 chop_s)
        else $error("chopped burst length wrong");
    full_len_a: assert property (rd && rl5 && o_mode0[1:0] == 2'h1 && i_addr[`A_BC_BIT] |-> ##7 o_dq_valid [*8])
        else $error("full burst length wrong");
    array_read_a: assert property (rd |=> o_array_rd != o_pattern_mode)
        else $error("array read steering wrong");
    array_write_a: assert property (wr |=> o_array_wr != o_pattern_mode)
        else $error("array write steering wrong");
    zq_start_a: assert property (zq |=> o_zq_busy && o_zq_pin_on && o_zq_long == $past(i_addr[`A_ZQ_LONG]))
        else $error("calibration did not start");
    zq_span_a: assert property ($fell(o_zq_busy) |-> busy_q == (long_q ? `T_ZQINIT_CK : `T_ZQCS_CK))
        else $error("calibration span wrong");
    zq_pin_off_a: assert property ($fell(o_zq_busy) |-> !o_zq_pin_on)
        else $error("calibration pin left on");
endmodule // dram_ctl_assertions
bind dram_mpr_mrs_zq_control dram_ctl_assertions u_chk (.i_ref_clk, .i_rst_n, .i_cs_n, .i_ras_n, .i_cas_n,
    .i_we_n, .i_ba, .i_addr, .o_dq_valid, .o_dq_bit, .o_array_rd, .o_array_wr, .o_mode0, .o_mode1, .o_mode3,
    .o_pattern_mode, .o_mode_busy, .o_zq_busy, .o_zq_long, .o_zq_pin_on);

//--- testbench/mem_ctl_model.sv
`timescale 1ns/1ps
`include "dram_ctl_defines.vh"
// ----------------------------------------
// controller model: drives the command bus
// ----------------------------------------
module mem_ctl_model (
    // clock
    input  wire        i_ref_clk,
    // command bus {cs_n, ras_n, cas_n, we_n}
    output reg  [3:0]  o_cmd,
    output reg  [2:0]  o_ba,
    output reg  [13:0] o_addr
);
    // deselected at time zero
    initial begin
        o_cmd  = 4'hf;
        o_ba   = 3'h0;
        o_addr = 14'h0000;
    end
    // one command for one clock, then deselect with stale lines inverted
    task cmd(input [3:0] c, input [2:0] b, input [13:0] a);
        begin
            @(posedge i_ref_clk);
            o_cmd  <= c;
            o_ba   <= b;
            o_addr <= a;
            @(posedge i_ref_clk);
            o_cmd  <= 4'hf;
            o_ba   <= ~b;
            o_addr <= ~a;
        end
    endtask
    // mode set from idle, then sit out the update wait
    task mrs(input [2:0] b, input [13:0] v);
        begin
            cmd(`CMD_MRS, b, v);
            repeat (`T_MOD_CK + 2) @(posedge i_ref_clk);
        end
    endtask
endmodule // mem_ctl_model

//--- testbench/tb.sv
`timescale 1ns/1ps
`include "dram_ctl_defines.vh"
`define CHK(n, e, g) begin check_count++; if ((e) !== (g)) begin miscompares++; \
    $display("unexpected %s: expected %h, seen %h", n, e, g); end end
module tb;
    // ----------------------------------------
    // clock, reset and wires
    // ----------------------------------------
    reg         i_ref_clk    = 1'b0;
    reg         i_rst_n      = 1'b0;
    reg  [7:0]  i_array_bits = 8'h3c;
    wire        i_cs_n, i_ras_n, i_cas_n, i_we_n, o_dq_valid, o_dq_bit, o_array_rd, o_array_wr;
    wire        o_pattern_mode, o_mode_busy, o_zq_busy, o_zq_long, o_zq_pin_on;
    wire [2:0]  i_ba;
    wire [13:0] i_addr, o_mode0, o_mode1, o_mode2, o_mode3;
    int         miscompares  = 0;
    int         check_count  = 0;
    int         i;
    mem_ctl_model ctl (.i_ref_clk, .o_cmd({i_cs_n, i_ras_n, i_cas_n, i_we_n}), .o_ba(i_ba), .o_addr(i_addr));
    dram_mpr_mrs_zq_control DUT (.i_ref_clk, .i_rst_n, .i_cs_n, .i_ras_n, .i_cas_n, .i_we_n, .i_ba, .i_addr,
        .i_array_bits, .o_dq_valid, .o_dq_bit, .o_array_rd, .o_array_wr, .o_mode0, .o_mode1, .o_mode2,
        .o_mode3, .o_pattern_mode, .o_mode_busy, .o_zq_busy, .o_zq_long, .o_zq_pin_on);
    // 20 ns clock
    initial begin
        forever #10 i_ref_clk = ~i_ref_clk;
    end
    // print counts and verdict, then stop
    task report_and_stop;
        begin
            $display("comparisons %0d, mismatches %0d", check_count, miscompares);
            if (miscompares == 0 && check_count > 0) $display("ALL CHECKS OK");
            else $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // wait for a burst, then compare n beats lsb first at the falling edge
    task burst(input [15:0] exp, input int n);
        int k;
        begin
            k = 0;
            @(negedge i_ref_clk);
            while (o_dq_valid !== 1'b1 && k < 20) begin
                @(negedge i_ref_clk);
                k++;
            end
            for (k = 0; k < n; k++) begin
                `CHK("beat", exp[k], o_dq_bit)
                @(negedge i_ref_clk);
            end
        end
    endtask
    // hang guard
    initial begin
        repeat (5000) @(posedge i_ref_clk);
        miscompares++;
        report_and_stop;
    end
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        ctl.mrs(3'h0, 14'h0011);
        ctl.mrs(3'h1, 14'h0042);
        ctl.mrs(3'h2, 14'h0123);
        ctl.mrs(3'h4, 14'h1fff);
        `CHK("mode0", 14'h0011, o_mode0)
        `CHK("mode1", 14'h0042, o_mode1)
        `CHK("mode2", 14'h0123, o_mode2)
        ctl.cmd(`CMD_WRITE, 3'h0, 14'h1000);
        ctl.cmd(`CMD_READ, 3'h0, 14'h1000);
        burst(16'h003c, 8);
        ctl.mrs(3'h3, 14'h0004);
        `CHK("pattern on", 1'b1, o_pattern_mode)
        `CHK("mode3", 14'h0004, o_mode3)
        ctl.cmd(`CMD_READ, 3'h0, 14'h1000);
        // second read eight clocks later continues the burst with no gap
        fork
            begin
                repeat (6) @(posedge i_ref_clk);
                ctl.cmd(`CMD_READ, 3'h0, 14'h1000);
            end
            burst(16'haaaa, 16);
        join
        ctl.cmd(`CMD_READ, 3'h0, 14'h0000);
        burst(16'h000a, 4);
        ctl.cmd(`CMD_READ, 3'h0, 14'h0004);
        burst(16'h000a, 4);
        ctl.mrs(3'h3, 14'h0000);
        `CHK("pattern off", 1'b0, o_pattern_mode)
        i_array_bits <= 8'h96;
        ctl.cmd(`CMD_READ, 3'h0, 14'h1000);
        burst(16'h0096, 8);
        for (i = 1; i >= 0; i--) begin
            ctl.cmd(`CMD_ZQ, 3'h0, i ? 14'h0400 : 14'h0000);
            repeat (2) @(negedge i_ref_clk);
            `CHK("zq busy", 1'b1, o_zq_busy)
            `CHK("zq long", i[0], o_zq_long)
            repeat (i ? `T_ZQINIT_CK : `T_ZQCS_CK) @(negedge i_ref_clk);
            `CHK("zq done", 1'b0, o_zq_busy)
            `CHK("zq pin", 1'b0, o_zq_pin_on)
        end
        report_and_stop;
    end
endmodule // tb
